// *** dv/acr_regs_test.sv ***
/*
  Self-checking bench for the converter register bank.
  Assumes acr_pkg and acr_regs are compiled first; the bench is the
  only AXI4-Lite master and also plays the converter core.
*/
`timescale 1ns/100ps
module acr_regs_test;
  import acr_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] chan_en;
  acr_conv_t conv = '0;
  acr_ctl_t ctl;
  int errors = 0;
  int check_count = 0;
  logic [1:0] rsp;
  logic [31:0] val;

  always #20 sys_clk = ~sys_clk;

  acr_regs uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .conv(conv), .ctl(ctl), .chan_en(chan_en),
    .irq(irq));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Both channels offered together, each dropped when taken. Outputs are
  // read at the falling edge: settled there, and equal to what the next
  // rising edge takes, so no race with the flops that launch them
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ad;
    logic wd;
    logic got;
    ad = 1'b0;
    wd = 1'b0;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge sys_clk);
      ad = ad || (awvalid && awready);
      wd = wd || (wvalid && wready);
      @(posedge sys_clk);
      if (ad) begin
        awvalid <= 1'b0;
      end
      if (wd) begin
        wvalid <= 1'b0;
      end
    end
    while (!got) begin
      @(negedge sys_clk);
      got = bvalid;
      r = bresp;
      @(posedge sys_clk);
    end
    // Spare edge so a following call never re-raises bready at once
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic got;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(negedge sys_clk);
      got = arready;
      @(posedge sys_clk);
    end
    arvalid <= 1'b0;
    got = 1'b0;
    while (!got) begin
      @(negedge sys_clk);
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
    end
    // Spare edge so a following call never re-raises rready at once
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Read a register and compare with an expected word
  task automatic rchk(input string nm, input logic [31:0] a,
                      input logic [31:0] e);
    rd(a, val, rsp);
    chk(nm, e, val);
  endtask

  // One-cycle pulse from the converter core
  task automatic pulse(input logic [2:0] l, input logic cal);
    conv.load <= l;
    conv.cal_done <= cal;
    @(posedge sys_clk);
    conv.load <= 3'h0;
    conv.cal_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk("mask", ACR_MASK_ADDR, 32'h0);
    rchk("mode", ACR_MODE_ADDR, 32'h0);
    rchk("status", ACR_STATUS_ADDR, 32'h0);
    chk("rresp", 32'h0, {30'h0, rsp});
    chk("chan_en", 32'h0, {29'h0, chan_en});
    chk("irq", 32'h0, {31'h0, irq});
    $display("test reset done");
  endtask

  // Every power code and every operating mode; bit 7 kept at zero
  task automatic t_mode;
    logic [7:0] v;
    logic [9:0] g;
    for (int i = 0; i < 5; i++) begin
      v = {1'b0, i[0], i[1], i[1:0], i[2:0]};
      g = (i == 1) ? ACR_GAIN_LP : (i == 2) ? ACR_GAIN_LPP : ACR_GAIN_FREE;
      wr(ACR_MODE_ADDR, {24'h0, v}, rsp);
      rchk("mode", ACR_MODE_ADDR, {24'h0, v});
      chk("res_sel", {31'h0, v[6]}, {31'h0, ctl.res_sel});
      chk("prec_ref", {31'h0, v[5]}, {31'h0, ctl.prec_ref});
      chk("pwr", {30'h0, v[4:3]}, {30'h0, ctl.pwr});
      chk("gain", {22'h0, g}, {22'h0, ctl.gain_fix});
      chk("lp_osc", {31'h0, (i == 1 || i == 2)}, {31'h0, ctl.lp_osc});
      chk("op", {29'h0, v[2:0]}, {29'h0, ctl.op});
    end
    $display("test mode done");
  endtask

  task automatic t_flags;
    conv.cur <= 16'h1234;
    conv.volt <= 16'h5678;
    conv.temp <= 16'h9ABC;
    wr(ACR_CHAN_EN_ADDR, 32'h7, rsp);
    chk("bresp", 32'h0, {30'h0, rsp});
    chk("chan_en", 32'h7, {29'h0, chan_en});
    rchk("chan_en", ACR_CHAN_EN_ADDR, 32'h7);
    pulse(3'h7, 1'b0);
    rchk("status", ACR_STATUS_ADDR, 32'h7);
    rchk("temp", ACR_TEMP_DATA_ADDR, 32'h9ABC);
    rchk("status", ACR_STATUS_ADDR, 32'h3);
    rchk("volt", ACR_VOLT_DATA_ADDR, 32'h5678);
    rchk("status", ACR_STATUS_ADDR, 32'h1);
    pulse(3'h6, 1'b0);
    rchk("cur", ACR_CUR_DATA_ADDR, 32'h1234);
    rchk("status", ACR_STATUS_ADDR, 32'h0);
    // Loads on disabled channels leave their flags alone
    wr(ACR_CHAN_EN_ADDR, 32'h2, rsp);
    pulse(3'h7, 1'b0);
    rchk("status", ACR_STATUS_ADDR, 32'h2);
    rchk("cur", ACR_CUR_DATA_ADDR, 32'h1234);
    $display("test flags done");
  endtask

  task automatic t_cal;
    wr(ACR_CHAN_EN_ADDR, 32'h5, rsp);
    pulse(3'h0, 1'b1);
    rchk("status", ACR_STATUS_ADDR, 32'h8005);
    wr(ACR_MODE_ADDR, 32'h0, rsp);
    rchk("status", ACR_STATUS_ADDR, 32'h0005);
    rchk("cur", ACR_CUR_DATA_ADDR, 32'h1234);
    $display("test calibration done");
  endtask

  task automatic t_irq;
    wr(ACR_MASK_ADDR, 32'h2, rsp);
    rchk("mask", ACR_MASK_ADDR, 32'h2);
    wr(ACR_CHAN_EN_ADDR, 32'h2, rsp);
    pulse(3'h2, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    wr(ACR_MASK_ADDR, 32'h1, rsp);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ACR_MASK_ADDR, 32'h2, rsp);
    wr(ACR_CLEAR_ADDR, 32'h2, rsp);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rchk("status", ACR_STATUS_ADDR, 32'h0);
    $display("test interrupt done");
  endtask

  // Unmapped place: error response, no data
  task automatic t_bad;
    wr(32'hFFFF0600, 32'hFF, rsp);
    chk("bresp", {30'h0, ACR_RESP_SLVERR}, {30'h0, rsp});
    rd(32'hFFFF0600, val, rsp);
    chk("rresp", {30'h0, ACR_RESP_SLVERR}, {30'h0, rsp});
    chk("rdata", 32'h0, val);
    $display("test unmapped done");
  endtask

  // ----------------------------------------------------------------
  // Sequence, verdict and watchdog
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_mode();
    t_flags();
    t_cal();
    t_irq();
    t_bad();
    complete_run();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    complete_run();
  end
endmodule

// *** hw/acr_pkg.sv ***
/*
  Shared constants and carrier types for the converter register bank.
  Assumes a 32-bit AXI4-Lite master and one system clock domain.
*/
package acr_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ACR_STATUS_ADDR = 32'hFFFF0500;
  localparam logic [31:0] ACR_MASK_ADDR = 32'hFFFF0504;
  localparam logic [31:0] ACR_MODE_ADDR = 32'hFFFF0508;
  localparam logic [31:0] ACR_CUR_DATA_ADDR = 32'hFFFF050C;
  localparam logic [31:0] ACR_VOLT_DATA_ADDR = 32'hFFFF0510;
  localparam logic [31:0] ACR_TEMP_DATA_ADDR = 32'hFFFF0514;
  localparam logic [31:0] ACR_CLEAR_ADDR = 32'hFFFF0518;
  localparam logic [31:0] ACR_CHAN_EN_ADDR = 32'hFFFF051C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ACR_RDY_CUR = 0;
  localparam int ACR_RDY_VOLT = 1;
  localparam int ACR_RDY_TEMP = 2;
  localparam int ACR_CAL_BIT = 15;
  localparam int ACR_MODE_RSV = 7;
  localparam int ACR_MODE_RES = 6;
  localparam int ACR_MODE_REF = 5;
  localparam int ACR_PWR_HI = 4;
  localparam int ACR_PWR_LO = 3;
  localparam int ACR_OP_HI = 2;
  localparam logic [7:0] ACR_MASK_RST = 8'h00;
  localparam logic [7:0] ACR_MODE_RST = 8'h00;
  localparam logic [15:0] ACR_STATUS_RST = 16'h0000;
  localparam logic [1:0] ACR_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Power modes, operation modes and forced gains
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACR_PWR_NORMAL = 2'h0,
    ACR_PWR_LOW = 2'h1,
    ACR_PWR_LOW_PLUS = 2'h2,
    ACR_PWR_UNDEF = 2'h3
  } acr_pwr_t;

  typedef enum logic [2:0] {
    ACR_OP_DOWN = 3'h0,
    ACR_OP_CONT = 3'h1,
    ACR_OP_SINGLE = 3'h2,
    ACR_OP_IDLE = 3'h3,
    ACR_OP_OFFCAL = 3'h4
  } acr_op_t;

  localparam logic [9:0] ACR_GAIN_FREE = 10'h000;
  localparam logic [9:0] ACR_GAIN_LP = 10'h080;
  localparam logic [9:0] ACR_GAIN_LPP = 10'h200;

  // Result loads coming from the converter core
  typedef struct packed {
    logic [2:0] load;
    logic [15:0] cur;
    logic [15:0] volt;
    logic [15:0] temp;
    logic cal_done;
  } acr_conv_t;

  // Decoded mode settings toward the analog side
  typedef struct packed {
    logic res_sel;
    logic prec_ref;
    acr_pwr_t pwr;
    logic [2:0] op;
    logic lp_osc;
    logic [9:0] gain_fix;
  } acr_ctl_t;
endpackage

// *** hw/acr_regs.sv ***
/*
  Register bank of a three-channel converter: result-ready flags,
  interrupt mask, mode register, results and channel enables, all
  behind an AXI4-Lite slave.
  Assumes the converter core pulses conv.load / conv.cal_done for one
  cycle of sys_clk, synchronous to it, and a master that keeps AXI
  valid/payload stable until taken.
*/
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps

module acr_regs
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter core side
  input wire acr_conv_t conv,
  output acr_ctl_t ctl,
  output logic [2:0] chan_en,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_ok;
    logic w_ok;
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] status;
    logic [7:0] mask;
    logic [7:0] mode;
    logic [2:0] chan_en;
    logic [15:0] cur;
    logic [15:0] volt;
    logic [15:0] temp;
    acr_ctl_t ctl;
    logic irq;
  } acr_state_t;

  acr_state_t st_r;
  acr_state_t st_nxt;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Bus handshakes, side effects of reads and writes, flag updates
  always_comb begin
    logic [15:0] set_v;
    logic [15:0] clr_v;
    st_nxt = st_r;
    set_v = 16'h0000;
    clr_v = 16'h0000;

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_ok = 1'b1;
      st_nxt.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_ok = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Write commits one cycle after both halves are held
    if (st_r.aw_ok && st_r.w_ok && !st_r.bvalid) begin
      st_nxt.aw_ok = 1'b0;
      st_nxt.w_ok = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = ACR_RESP_OKAY;
      case (st_r.waddr)
        ACR_MASK_ADDR: begin
          if (st_r.wstrb[0]) begin
            st_nxt.mask = st_r.wdata[7:0];
          end
        end
        ACR_MODE_ADDR: begin
          // Reserved bit is not stored so it always reads zero
          if (st_r.wstrb[0]) begin
            st_nxt.mode = st_r.wdata[7:0];
            st_nxt.mode[ACR_MODE_RSV] = 1'b0;
          end
          clr_v[ACR_CAL_BIT] = 1'b1;
        end
        ACR_CLEAR_ADDR: begin
          if (st_r.wstrb[0]) begin
            clr_v[7:0] = st_r.wdata[7:0];
          end
          if (st_r.wstrb[1]) begin
            clr_v[15:8] = st_r.wdata[15:8];
          end
        end
        ACR_CHAN_EN_ADDR: begin
          if (st_r.wstrb[0]) begin
            st_nxt.chan_en = st_r.wdata[2:0];
          end
        end
        ACR_STATUS_ADDR, ACR_CUR_DATA_ADDR, ACR_VOLT_DATA_ADDR,
        ACR_TEMP_DATA_ADDR: begin
          st_nxt.bresp = ACR_RESP_OKAY; // Read-only, write ignored
        end
        default: begin
          st_nxt.bresp = ACR_RESP_SLVERR;
        end
      endcase
    end

    // Read: data latched on the address handshake
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = ACR_RESP_OKAY;
      st_nxt.rdata = 32'h00000000;
      case (s_axi_araddr)
        ACR_STATUS_ADDR: st_nxt.rdata[15:0] = st_r.status;
        ACR_MASK_ADDR: st_nxt.rdata[7:0] = st_r.mask;
        ACR_MODE_ADDR: st_nxt.rdata[7:0] = st_r.mode;
        ACR_CHAN_EN_ADDR: st_nxt.rdata[2:0] = st_r.chan_en;
        ACR_CLEAR_ADDR: st_nxt.rdata = 32'h00000000;
        ACR_CUR_DATA_ADDR: begin
          st_nxt.rdata[15:0] = st_r.cur;
          clr_v[ACR_RDY_CUR] = 1'b1;
          clr_v[ACR_RDY_VOLT] = 1'b1;
          clr_v[ACR_RDY_TEMP] = 1'b1;
        end
        ACR_VOLT_DATA_ADDR: begin
          st_nxt.rdata[15:0] = st_r.volt;
          clr_v[ACR_RDY_VOLT] = 1'b1;
        end
        ACR_TEMP_DATA_ADDR: begin
          st_nxt.rdata[15:0] = st_r.temp;
          clr_v[ACR_RDY_TEMP] = 1'b1;
        end
        default: st_nxt.rresp = ACR_RESP_SLVERR;
      endcase
    end

    // Result loads; ready flags only follow enabled channels
    if (conv.load[ACR_RDY_CUR]) begin
      st_nxt.cur = conv.cur;
    end
    if (conv.load[ACR_RDY_VOLT]) begin
      st_nxt.volt = conv.volt;
    end
    if (conv.load[ACR_RDY_TEMP]) begin
      st_nxt.temp = conv.temp;
    end
    set_v[ACR_RDY_CUR] = conv.load[ACR_RDY_CUR]
                         && st_r.chan_en[ACR_RDY_CUR];
    set_v[ACR_RDY_VOLT] = conv.load[ACR_RDY_VOLT]
                          && st_r.chan_en[ACR_RDY_VOLT];
    set_v[ACR_RDY_TEMP] = conv.load[ACR_RDY_TEMP]
                          && st_r.chan_en[ACR_RDY_TEMP];
    if (conv.cal_done) begin
      set_v[ACR_RDY_TEMP:ACR_RDY_CUR] =
        set_v[ACR_RDY_TEMP:ACR_RDY_CUR] | st_r.chan_en;
      set_v[ACR_CAL_BIT] = 1'b1;
    end
    // A set in the same cycle as a clear wins, so no event is lost
    st_nxt.status = (st_r.status & ~clr_v) | set_v;

    // Handshake readiness comes from the next state
    st_nxt.awready = !st_nxt.aw_ok && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_ok && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;

    // Decoded mode outputs
    st_nxt.ctl.res_sel = st_nxt.mode[ACR_MODE_RES];
    st_nxt.ctl.prec_ref = st_nxt.mode[ACR_MODE_REF];
    st_nxt.ctl.pwr = acr_pwr_t'(st_nxt.mode[ACR_PWR_HI:ACR_PWR_LO]);
    st_nxt.ctl.op = st_nxt.mode[ACR_OP_HI:0];
    case (st_nxt.ctl.pwr)
      ACR_PWR_LOW: begin
        st_nxt.ctl.gain_fix = ACR_GAIN_LP;
        st_nxt.ctl.lp_osc = 1'b1;
      end
      ACR_PWR_LOW_PLUS: begin
        st_nxt.ctl.gain_fix = ACR_GAIN_LPP;
        st_nxt.ctl.lp_osc = 1'b1;
      end
      default: begin
        // Undefined code behaves as normal mode
        st_nxt.ctl.gain_fix = ACR_GAIN_FREE;
        st_nxt.ctl.lp_osc = 1'b0;
      end
    endcase

    st_nxt.irq = |(st_nxt.status[7:0] & st_nxt.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.mask <= ACR_MASK_RST;
      st_r.mode <= ACR_MODE_RST;
      st_r.status <= ACR_STATUS_RST;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign ctl = st_r.ctl;
  assign chan_en = st_r.chan_en;
  assign irq = st_r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking acr_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  wire rd_cur = s_axi_arvalid && s_axi_arready
                && s_axi_araddr == ACR_CUR_DATA_ADDR;
  wire rd_volt = s_axi_arvalid && s_axi_arready
                 && s_axi_araddr == ACR_VOLT_DATA_ADDR;
  wire rd_temp = s_axi_arvalid && s_axi_arready
                 && s_axi_araddr == ACR_TEMP_DATA_ADDR;
  wire wr_mode = st_r.aw_ok && st_r.w_ok && !st_r.bvalid
                 && st_r.waddr == ACR_MODE_ADDR;
  wire wr_mask = st_r.aw_ok && st_r.w_ok && !st_r.bvalid
                 && st_r.waddr == ACR_MASK_ADDR && st_r.wstrb[0];

  a_temp_set: assert property (
    conv.load[ACR_RDY_TEMP] && chan_en[ACR_RDY_TEMP]
    |=> st_r.status[ACR_RDY_TEMP]) else $error("temp ready not set");
  a_temp_clr: assert property (
    (rd_cur || rd_temp) && !conv.load[ACR_RDY_TEMP] && !conv.cal_done
    |=> !st_r.status[ACR_RDY_TEMP]) else $error("temp ready not cleared");
  a_volt_set: assert property (
    conv.load[ACR_RDY_VOLT] && chan_en[ACR_RDY_VOLT]
    |=> st_r.status[ACR_RDY_VOLT]) else $error("volt ready not set");
  a_volt_clr: assert property (
    (rd_cur || rd_volt) && !conv.load[ACR_RDY_VOLT] && !conv.cal_done
    |=> !st_r.status[ACR_RDY_VOLT]) else $error("volt ready not cleared");
  a_cur_set: assert property (
    conv.load[ACR_RDY_CUR] && chan_en[ACR_RDY_CUR]
    |=> st_r.status[ACR_RDY_CUR]) else $error("cur ready not set");
  a_cur_keep: assert property (
    st_r.status[ACR_RDY_CUR] && !rd_cur
    && !(st_r.aw_ok && st_r.w_ok && st_r.waddr == ACR_CLEAR_ADDR)
    |=> st_r.status[ACR_RDY_CUR]) else $error("cur ready lost");
  a_cal_ready: assert property (
    conv.cal_done |=> (st_r.status[ACR_RDY_TEMP:ACR_RDY_CUR]
    & $past(chan_en)) == $past(chan_en) && st_r.status[ACR_CAL_BIT])
    else $error("cal flags");
  // Interrupt must follow the registered status and mask, not lag them
  a_irq_gate: assert property (
    irq == |(st_r.status[7:0] & st_r.mask))
    else $error("irq mismatch");
  a_mask_rst: assert property (
    $rose(rst_n) |-> st_r.mask == ACR_MASK_RST)
    else $error("mask reset");
  a_mask_wr: assert property (
    wr_mask |=> st_r.mask == $past(st_r.wdata[7:0]))
    else $error("mask write lost");
  a_mode_cal: assert property (
    wr_mode && !conv.cal_done |=> !st_r.status[ACR_CAL_BIT])
    else $error("cal not cleared");
  a_mode_rsv: assert property (
    !st_r.mode[ACR_MODE_RSV])
    else $error("reserved bit set");
  a_gain_lp: assert property (
    ctl.pwr == ACR_PWR_LOW |-> ctl.gain_fix == ACR_GAIN_LP && ctl.lp_osc)
    else $error("low power gain");
  a_gain_lpp: assert property (
    ctl.pwr == ACR_PWR_LOW_PLUS |-> ctl.gain_fix == ACR_GAIN_LPP)
    else $error("lpp gain");
  a_mode_dec: assert property (
    ctl.op == st_r.mode[ACR_OP_HI:0])
    else $error("mode decode");
  a_res_sel: assert property (
    ctl.res_sel == st_r.mode[ACR_MODE_RES])
    else $error("resistor select");
  a_prec_ref: assert property (
    ctl.prec_ref == st_r.mode[ACR_MODE_REF])
    else $error("reference select");

  c_wr_mode: cover property (wr_mode);
  c_rd_cur: cover property (rd_cur && st_r.status[0]);
  c_irq: cover property ($rose(irq));
  c_cal: cover property (conv.cal_done && chan_en != 3'h0);
endmodule
